// ### pulse_src.sv
/* Pulse sensor model on the input terminals.
   Assumes the caller waits for each send to return. */
`timescale 1ns/100ps
module pulse_src #(
  parameter int N = 4
) (
  input  wire logic         clk,
  output logic     [N-1:0]  term_in
);
  initial term_in = '0;
  // Slow pulses, at least 3 cycles high and low
  task send(input int t, input int n);
    repeat (n) begin
      @(posedge clk) term_in[t] <= 1'b1;
      repeat (3) @(posedge clk);
      term_in[t] <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// ### swing_length_count_unit.sv
/*
  Swing frequency generator, length meter and event counter of a drive
  controller, with an AXI4-Lite register slave and one interrupt output.
  Assumes terminal inputs synchronous to CLK and pulses slower than CLK/4;
  frequency ports in 0.01 Hz steps, supplied by the drive core.

*/
`timescale 1ns/100ps
`include "swing_params.svh"

module swing_length_count_unit
  import swing_pkg::*;
#(
  parameter int N_DI        = 4,
  parameter int N_DO        = 4,
  parameter int ADDR_W      = 8,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic              CLK,
  input  wire logic              NRST,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic [15:0]       CENTRE_FREQUENCY_SOURCE,
  input  wire logic [15:0]       MAX_OUTPUT_FREQUENCY,
  input  wire logic [15:0]       FREQ_UPPER_LIMIT,
  input  wire logic [15:0]       FREQ_LOWER_LIMIT,
  input  wire logic [N_DI-1:0]   TERMINAL_IN,
  output logic [N_DO-1:0]        TERMINAL_OUT,
  output logic [15:0]            FREQ_OUT,
  output logic                   IRQ
);

  initial begin
    if (N_DI < 1 || N_DI > 4 || N_DO < 1 || N_DO > 4 || ADDR_W < 8 || TICK_CYCLES < 128)
      $error("swing_length_count_unit: unsupported parameter values");
  end

  localparam int NUM_W = 48;

  function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    sat16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    for (int b = 0; b < 4; b++)
      merge32[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
  endfunction

  function automatic logic do_fn(input logic [7:0] code, input logic f_hit,
                                 input logic i_hit, input logic l_hit);
    do_fn = (code == `FN_FINAL_HIT && f_hit) || (code == `FN_INTER_HIT && i_hit) ||
            (code == `FN_LEN_HIT && l_hit);
  endfunction

  // Register bank
  logic [15:0] swing_base_reg, swing_amp_reg, jump_pct_reg, period_reg, rise_ratio_reg;
  logic [15:0] target_len_reg, measured_len_reg, ppm_reg, final_cnt_reg, inter_cnt_reg;
  logic [31:0] di_func_reg, do_func_reg;
  logic [15:0] count_reg;
  logic [2:0]  irq_stat_reg, irq_mask_reg;

  // Bus slave state
  logic              aw_held_reg, w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;

  wire aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_fire  = S_AXI_WVALID & S_AXI_WREADY;
  wire b_fire  = S_AXI_BVALID & S_AXI_BREADY;
  wire ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  wire r_fire  = S_AXI_RVALID & S_AXI_RREADY;
  wire wr_fire = aw_held_reg & w_held_reg & ~S_AXI_BVALID;

  wire [7:0]  wr_ofs = {aw_addr_reg[7:2], 2'h0};
  wire [7:0]  rd_ofs = {S_AXI_ARADDR[7:2], 2'h0};
  wire        wr_hi_ok = (ADDR_W == 8) || (aw_addr_reg >> 8) == '0;
  wire        rd_hi_ok = (ADDR_W == 8) || (S_AXI_ARADDR >> 8) == '0;

  function automatic logic mapped(input logic [7:0] ofs);
    mapped = (ofs <= `OFS_FREQ);
  endfunction

  wire        wr_ok = wr_fire & wr_hi_ok & mapped(wr_ofs);
  wire [31:0] wr_old;
  wire [31:0] wr_val = merge32(wr_old, wdata_reg, wstrb_reg);
  wire [15:0] wr_lo  = wr_val[15:0];

  function automatic logic [31:0] reg_word(input logic [7:0] ofs);
    case (ofs)
      `OFS_SWING_BASE:   reg_word = {16'h0000, swing_base_reg};
      `OFS_SWING_AMP:    reg_word = {16'h0000, swing_amp_reg};
      `OFS_JUMP_AMP:     reg_word = {16'h0000, jump_pct_reg};
      `OFS_SWING_PERIOD: reg_word = {16'h0000, period_reg};
      `OFS_RISE_RATIO:   reg_word = {16'h0000, rise_ratio_reg};
      `OFS_TARGET_LEN:   reg_word = {16'h0000, target_len_reg};
      `OFS_MEASURED_LEN: reg_word = {16'h0000, measured_len_reg};
      `OFS_PULSES_PM:    reg_word = {16'h0000, ppm_reg};
      `OFS_FINAL_CNT:    reg_word = {16'h0000, final_cnt_reg};
      `OFS_INTER_CNT:    reg_word = {16'h0000, inter_cnt_reg};
      `OFS_DI_FUNC:      reg_word = di_func_reg;
      `OFS_DO_FUNC:      reg_word = do_func_reg;
      `OFS_COUNT:        reg_word = {16'h0000, count_reg};
      `OFS_IRQ_STATUS:   reg_word = {29'h0, irq_stat_reg};
      `OFS_IRQ_MASK:     reg_word = {29'h0, irq_mask_reg};
      `OFS_FREQ:         reg_word = {16'h0000, FREQ_OUT};
      default:           reg_word = 32'h0000_0000;
    endcase
  endfunction

  assign wr_old = reg_word(wr_ofs);
  wire [31:0] rd_val = reg_word(rd_ofs);
  wire        rd_ok  = rd_hi_ok & mapped(rd_ofs);

  wire sel_w_amp  = wr_ok && wr_ofs == `OFS_SWING_AMP;
  wire sel_w_meas = wr_ok && wr_ofs == `OFS_MEASURED_LEN;
  wire sel_w_stat = wr_ok && wr_ofs == `OFS_IRQ_STATUS;
  wire cnt_clr    = wr_ok && wr_ofs == `OFS_CTRL && wr_val[`CTRL_BIT_CNT_CLR];

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (w_fire) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= S_AXI_WDATA;
        wstrb_reg    <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (b_fire) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `RESP_OKAY;
    end else if (ar_fire) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_ok ? rd_val : 32'h0000_0000;
      S_AXI_RRESP   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r_fire) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
    end
  end

  // Settings; out-of-range writes saturate to the legal range, except the swing base, which keeps bit 0 only, and the interrupt mask, which keeps bits 2:0 only
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      swing_base_reg <= 16'h0000;
      swing_amp_reg  <= 16'h0000;
      jump_pct_reg   <= 16'h0000;
      period_reg     <= `RST_SWING_PERIOD;
      rise_ratio_reg <= `RST_RISE_RATIO;
      target_len_reg <= `RST_TARGET_LEN;
      ppm_reg        <= `RST_PULSES_PM;
      final_cnt_reg  <= `RST_FINAL_CNT;
      inter_cnt_reg  <= `RST_INTER_CNT;
      di_func_reg    <= 32'h0000_0000;
      do_func_reg    <= 32'h0000_0000;
      irq_mask_reg   <= 3'h0;
    end else if (wr_ok) begin
      case (wr_ofs)
        `OFS_SWING_BASE:   swing_base_reg <= {15'h0000, wr_lo[0]};
        `OFS_SWING_AMP:    swing_amp_reg  <= sat16(wr_lo, 16'h0000, `PCT_FULL);
        `OFS_JUMP_AMP:     jump_pct_reg   <= sat16(wr_lo, 16'h0000, `JUMP_PCT_MAX);
        `OFS_SWING_PERIOD: period_reg     <= sat16(wr_lo, 16'h0000, `PERIOD_MAX);
        `OFS_RISE_RATIO:   rise_ratio_reg <= sat16(wr_lo, 16'h0000, `PCT_FULL);
        `OFS_TARGET_LEN:   target_len_reg <= wr_lo;
        `OFS_PULSES_PM:    ppm_reg        <= sat16(wr_lo, `PPM_MIN, 16'hFFFF);
        `OFS_FINAL_CNT:    final_cnt_reg  <= sat16(wr_lo, `CNT_MIN, 16'hFFFF);
        `OFS_INTER_CNT:    inter_cnt_reg  <= sat16(wr_lo, `CNT_MIN, 16'hFFFF);
        `OFS_DI_FUNC:      di_func_reg    <= wr_val;
        `OFS_DO_FUNC:      do_func_reg    <= wr_val;
        `OFS_IRQ_MASK:     irq_mask_reg   <= wr_val[2:0];
        default:           ;
      endcase
    end
  end

  // Terminal synchronisers and function decode
  logic [N_DI-1:0] sync1_reg, sync2_reg;
  logic [N_DI-1:0] cnt_sel, len_sel, rst_sel;
  logic            cnt_prev_reg, len_prev_reg;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= TERMINAL_IN;
      sync2_reg <= sync1_reg;
    end
  end

  for (genvar g = 0; g < N_DI; g++) begin : g_di
    assign cnt_sel[g] = di_func_reg[8*g +: 8] == `FN_CNT_IN;
    assign len_sel[g] = di_func_reg[8*g +: 8] == `FN_LEN_IN;
    assign rst_sel[g] = di_func_reg[8*g +: 8] == `FN_LEN_RST;
  end

  wire cnt_level = |(sync2_reg & cnt_sel);
  wire len_level = |(sync2_reg & len_sel);
  wire len_clear = |(sync2_reg & rst_sel) | sel_w_meas;
  wire cnt_edge  = cnt_level & ~cnt_prev_reg;
  wire len_edge  = len_level & ~len_prev_reg;

  // Counter and length pulses
  logic [31:0] pulse_cnt_reg;
  wire final_hit = count_reg >= final_cnt_reg;
  wire inter_hit = count_reg >= inter_cnt_reg;
  wire len_hit   = measured_len_reg > target_len_reg;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_prev_reg  <= 1'b0;
      len_prev_reg  <= 1'b0;
      count_reg     <= 16'h0000;
      pulse_cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_prev_reg <= cnt_level;
      len_prev_reg <= len_level;
      if (cnt_clr)
        count_reg <= 16'h0000;
      else if (cnt_edge && !final_hit)
        count_reg <= count_reg + 16'h0001;
      if (len_clear)
        pulse_cnt_reg <= 32'h0000_0000;
      else if (len_edge)
        pulse_cnt_reg <= pulse_cnt_reg + 32'h0000_0001;
    end
  end

  // Swing time base and triangle phase
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
  logic        tick_reg, tick_d_reg, rising_reg;
  logic [31:0] t_reg;
  wire         swing_on = swing_amp_reg != 16'h0000 && period_reg != 16'h0000;
  wire [31:0]  rise_len = period_reg * rise_ratio_reg;
  wire [31:0]  fall_len = period_reg * (`PCT_FULL - rise_ratio_reg);
  wire [31:0]  seg_len  = rising_reg ? rise_len : fall_len;
  wire [31:0]  t_inc    = t_reg + 32'h0000_0001;
  wire         tick_wrap = tick_cnt_reg == $bits(tick_cnt_reg)'(TICK_CYCLES - 1);

  // Divider starts one cycle after the tick so it sees the updated phase
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
      tick_d_reg   <= 1'b0;
    end else begin
      tick_reg     <= tick_wrap;
      tick_d_reg   <= tick_reg;
      tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      t_reg      <= 32'h0000_0000;
      rising_reg <= 1'b1;
    end else if (tick_reg) begin
      if (!swing_on) begin
        t_reg      <= 32'h0000_0000;
        rising_reg <= 1'b1;
      end else if (t_inc >= seg_len) begin
        t_reg      <= 32'h0000_0000;
        rising_reg <= ~rising_reg;
      end else begin
        t_reg <= t_inc;
      end
    end
  end

  // Span, jump and offset
  wire [15:0] base_freq = swing_base_reg[0] ? MAX_OUTPUT_FREQUENCY
                                            : CENTRE_FREQUENCY_SOURCE;
  wire [31:0] aw_prod   = base_freq * swing_amp_reg;
  wire [15:0] aw_w      = 16'(aw_prod / 32'(`PCT_FULL));
  wire [31:0] jmp_prod  = aw_w * jump_pct_reg;
  wire [15:0] jmp_w     = 16'(jmp_prod / 32'(`PCT_FULL));
  wire [16:0] span_w    = {aw_w, 1'b0} - {1'b0, jmp_w};

  // Shared serial divider: swing position, then length
  div_state_t       div_state_reg;
  logic [32:0]      rem_reg;
  logic [NUM_W-1:0] quo_reg;
  logic [31:0]      den_reg;
  logic [5:0]       bit_cnt_reg;

  wire [32:0] trial   = {rem_reg[31:0], quo_reg[NUM_W-1]};
  wire        ge      = trial >= {1'b0, den_reg};
  wire        div_end = div_state_reg != DIV_IDLE && bit_cnt_reg == 6'h00;
  wire [NUM_W-1:0] swing_num = NUM_W'(span_w) * NUM_W'(t_reg);
  wire [NUM_W-1:0] len_num   = NUM_W'(pulse_cnt_reg) * NUM_W'(`LEN_SCALE);

  wire [16:0] q_lim = (den_reg == 32'h0000_0000) ? 17'h00000 :
                      (quo_reg > NUM_W'(span_w)) ? span_w : quo_reg[16:0];
  wire signed [19:0] off_rise = -$signed({4'h0, aw_w}) + $signed({4'h0, jmp_w})
                                + $signed({3'h0, q_lim});
  wire signed [19:0] off_fall = $signed({4'h0, aw_w}) - $signed({4'h0, jmp_w})
                                - $signed({3'h0, q_lim});
  wire signed [19:0] offset   = !swing_on ? 20'sh00000 : (rising_reg ? off_rise : off_fall);
  wire signed [19:0] f_raw    = $signed({4'h0, CENTRE_FREQUENCY_SOURCE}) + offset;
  wire signed [19:0] up_s     = $signed({4'h0, FREQ_UPPER_LIMIT});
  wire signed [19:0] lo_s     = $signed({4'h0, FREQ_LOWER_LIMIT});
  wire signed [19:0] f_hi     = (f_raw > up_s) ? up_s : f_raw;
  wire signed [19:0] f_clip   = (f_hi < lo_s) ? lo_s : f_hi;
  wire [15:0] len_q = (quo_reg > NUM_W'(16'hFFFF)) ? 16'hFFFF : quo_reg[15:0];

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      div_state_reg <= DIV_IDLE;
      rem_reg       <= '0;
      quo_reg       <= '0;
      den_reg       <= 32'h0000_0000;
      bit_cnt_reg   <= 6'h00;
    end else if (div_state_reg == DIV_IDLE) begin
      if (tick_d_reg) begin
        div_state_reg <= DIV_SWING;
        rem_reg       <= '0;
        quo_reg       <= swing_num;
        den_reg       <= seg_len;
        bit_cnt_reg   <= 6'(NUM_W);
      end
    end else if (!div_end) begin
      rem_reg     <= ge ? trial - {1'b0, den_reg} : trial;
      quo_reg     <= {quo_reg[NUM_W-2:0], ge};
      bit_cnt_reg <= bit_cnt_reg - 6'h01;
    end else if (div_state_reg == DIV_SWING) begin
      div_state_reg <= DIV_LEN;
      rem_reg       <= '0;
      quo_reg       <= len_num;
      den_reg       <= {16'h0000, ppm_reg};
      bit_cnt_reg   <= 6'(NUM_W);
    end else begin
      div_state_reg <= DIV_IDLE;
    end
  end

  // A clear during a length division drops that stale result
  logic len_stale_reg;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      FREQ_OUT         <= 16'h0000;
      measured_len_reg <= 16'h0000;
      len_stale_reg    <= 1'b0;
    end else begin
      if (div_end && div_state_reg == DIV_SWING)
        FREQ_OUT <= 16'(f_clip);
      if (len_clear)
        len_stale_reg <= 1'b1;
      else if (div_end && div_state_reg == DIV_SWING)
        len_stale_reg <= 1'b0;
      if (len_clear)
        measured_len_reg <= 16'h0000;
      else if (div_end && div_state_reg == DIV_LEN && !len_stale_reg)
        measured_len_reg <= len_q;
    end
  end

  // Output terminals and interrupts
  logic [N_DO-1:0] do_next;
  logic [2:0]      hit_prev_reg;
  wire  [2:0]      hits   = {len_hit, inter_hit, final_hit};
  wire  [2:0]      events = hits & ~hit_prev_reg;
  wire  [2:0]      w1c    = sel_w_stat ? wr_val[2:0] : 3'h0;

  for (genvar g = 0; g < N_DO; g++) begin : g_do
    assign do_next[g] = do_fn(do_func_reg[8*g +: 8], final_hit, inter_hit, len_hit);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TERMINAL_OUT <= '0;
      hit_prev_reg <= 3'h0;
      irq_stat_reg <= 3'h0;
      IRQ          <= 1'b0;
    end else begin
      TERMINAL_OUT <= do_next;
      hit_prev_reg <= hits;
      irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
      IRQ          <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Checks
  AST_FREQ_CLAMP: assert property (@(posedge CLK) disable iff (!NRST)
    (div_end && div_state_reg == DIV_SWING && FREQ_LOWER_LIMIT <= FREQ_UPPER_LIMIT)
    |=> (FREQ_OUT <= $past(FREQ_UPPER_LIMIT) && FREQ_OUT >= $past(FREQ_LOWER_LIMIT)))
    else $error("output frequency outside limits");

  AST_NO_SWING: assert property (@(posedge CLK) disable iff (!NRST)
    (div_end && div_state_reg == DIV_SWING && swing_amp_reg == 16'h0000
     && CENTRE_FREQUENCY_SOURCE >= FREQ_LOWER_LIMIT
     && CENTRE_FREQUENCY_SOURCE <= FREQ_UPPER_LIMIT)
    |=> FREQ_OUT == $past(CENTRE_FREQUENCY_SOURCE))
    else $error("zero amplitude output differs from centre");

  AST_JUMP_CAP: assert property (@(posedge CLK) disable iff (!NRST)
    jump_pct_reg <= `JUMP_PCT_MAX && jmp_w <= aw_w)
    else $error("jump step above half span");

  AST_COUNT_INC: assert property (@(posedge CLK) disable iff (!NRST)
    (cnt_edge && !final_hit && !cnt_clr) |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("count event not counted");

  AST_COUNT_STOP: assert property (@(posedge CLK) disable iff (!NRST)
    (final_hit && !cnt_clr) |=> count_reg == $past(count_reg))
    else $error("counter moved after final target");

  AST_SINGLE_EDGE: assert property (@(posedge CLK) disable iff (!NRST)
    (!cnt_edge && !cnt_clr) |=> count_reg == $past(count_reg))
    else $error("counter moved without a pulse edge");

  AST_LEN_RESET: assert property (@(posedge CLK) disable iff (!NRST)
    len_clear |=> (pulse_cnt_reg == 32'h0000_0000 && measured_len_reg == 16'h0000))
    else $error("length not cleared");

  AST_LEN_OUT: assert property (@(posedge CLK) disable iff (!NRST)
    (len_hit && do_func_reg[8*(N_DO-1) +: 8] == `FN_LEN_HIT) |=> TERMINAL_OUT[N_DO-1])
    else $error("length reached output stayed off");

  AST_INTER_OUT: assert property (@(posedge CLK) disable iff (!NRST)
    (inter_hit && !final_hit && do_func_reg[7:0] == `FN_INTER_HIT) |=> TERMINAL_OUT[0])
    else $error("intermediate output stayed off");

  AST_REVERSAL: assert property (@(posedge CLK) disable iff (!NRST)
    (tick_reg && swing_on && t_inc >= seg_len) |=> (rising_reg != $past(rising_reg)
                                                     && t_reg == 32'h0000_0000))
    else $error("triangle did not reverse at segment end");

  AST_SEG_BOUND: assert property (@(posedge CLK) disable iff (!NRST)
    (tick_reg && swing_on && seg_len != 32'h0000_0000) |=> t_reg < $past(seg_len))
    else $error("phase beyond segment length");

endmodule

// ### swing_length_count_unit_bench.sv
/* Register and terminal tests of the swing, length and count unit.
   Assumes pulse_src drives the terminals and TICK_CYCLES of 128. */
`timescale 1ns/100ps
module swing_length_count_unit_bench
  import swing_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  aw = 8'h00, ar = 8'h00;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [31:0] wd = 32'h0, rdat, rd;
  logic [1:0]  bresp, rresp, rr;
  logic        awr, wrdy, bvalid, arr, rvalid, irq;
  logic [3:0]  term_in, term_out, ws = 4'hF;
  logic [15:0] fout, cf = 16'h1388, fup = 16'h0FA0;
  int          num_errors = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  swing_length_count_unit #(.TICK_CYCLES(128)) u_swing_length_count_unit (
    .CLK(clk), .NRST(rst_n), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CENTRE_FREQUENCY_SOURCE(cf), .MAX_OUTPUT_FREQUENCY(16'h2710),
    .FREQ_UPPER_LIMIT(fup), .FREQ_LOWER_LIMIT(16'h0000),
    .TERMINAL_IN(term_in), .TERMINAL_OUT(term_out), .FREQ_OUT(fout), .IRQ(irq));
  pulse_src #(.N(4)) u_pulse_src (.clk(clk), .term_in(term_in));
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (!(bready && bvalid));
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      rd = rdat;
      rr = rresp;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rd, e);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h0C, 32'h64);
    rc(8'h10, 32'h1F4);
    rc(8'h1C, 32'h3E8);
    wr(8'h08, 32'h3FF);
    rc(8'h08, 32'h1F4);
    rc(8'h44, 32'h0);
    chk({30'h0, rr}, 32'h2);
    wr(8'h20, 32'h3);
    wr(8'h24, 32'h2);
    wr(8'h28, 32'h19);
    wr(8'h2C, 32'h809);
    wr(8'h38, 32'h1);
    u_pulse_src.send(3, 1);
    rc(8'h30, 32'h0);
    u_pulse_src.send(0, 2);
    repeat (8) @(posedge clk);
    rc(8'h30, 32'h2);
    chk(term_out, 32'h1);
    u_pulse_src.send(0, 2);
    repeat (8) @(posedge clk);
    rc(8'h30, 32'h3);
    chk(term_out, 32'h3);
    chk(irq, 32'h1);
    wr(8'h34, 32'h1);
    repeat (3) @(posedge clk);
    chk(irq, 32'h0);
    rc(8'h34, 32'h2);
    repeat (300) @(posedge clk);
    chk(fout, 32'h0FA0);
    fup <= 16'h2710;
    wr(8'h04, 32'h64);
    repeat (300) @(posedge clk);
    chk(fout, 32'h128E);
    cf <= 16'h1770;
    wr(8'h00, 32'h1);
    repeat (300) @(posedge clk);
    chk(fout, 32'h157C);
    fup <= 16'h1000;
    repeat (300) @(posedge clk);
    rc(8'h40, 32'h1000);
    wr(8'h1C, 32'h5);
    wr(8'h14, 32'h5);
    wr(8'h28, 32'h1C1B19);
    wr(8'h2C, 32'h0A000809);
    u_pulse_src.send(1, 3);
    repeat (300) @(posedge clk);
    rc(8'h18, 32'h6);
    chk(term_out, 32'hB);
    u_pulse_src.send(2, 1);
    repeat (300) @(posedge clk);
    rc(8'h18, 32'h0);
    chk(term_out, 32'h3);
    ws <= 4'h2;
    wr(8'h14, 32'hAB00);
    ws <= 4'hF;
    rc(8'h14, 32'hAB05);
    wr(8'h3C, 32'h1);
    rc(8'h30, 32'h0);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict;
  end
endmodule

// ### swing_params.svh
/*
  Constants of the swing, length and count unit: register offsets, field
  positions, reset values, terminal function codes and timing counts.
  Assumes a 200 MHz controller clock and 32-bit AXI4-Lite register words.
*/
`ifndef SWING_PARAMS_SVH
`define SWING_PARAMS_SVH

// Register byte offsets
`define OFS_SWING_BASE    8'h00
`define OFS_SWING_AMP     8'h04
`define OFS_JUMP_AMP      8'h08
`define OFS_SWING_PERIOD  8'h0C
`define OFS_RISE_RATIO    8'h10
`define OFS_TARGET_LEN    8'h14
`define OFS_MEASURED_LEN  8'h18
`define OFS_PULSES_PM     8'h1C
`define OFS_FINAL_CNT     8'h20
`define OFS_INTER_CNT     8'h24
`define OFS_DI_FUNC       8'h28
`define OFS_DO_FUNC       8'h2C
`define OFS_COUNT         8'h30
`define OFS_IRQ_STATUS    8'h34
`define OFS_IRQ_MASK      8'h38
`define OFS_CTRL          8'h3C
`define OFS_FREQ          8'h40

// Field positions
`define IRQ_BIT_FINAL     0
`define IRQ_BIT_INTER     1
`define IRQ_BIT_LEN       2
`define CTRL_BIT_CNT_CLR  0

// Reset values and limits (percent in 0.1 %, period in 0.1 s, pulses in 0.1)
`define RST_SWING_PERIOD  16'h0064
`define RST_RISE_RATIO    16'h01F4
`define RST_TARGET_LEN    16'h03E8
`define RST_PULSES_PM     16'h03E8
`define RST_FINAL_CNT     16'h03E8
`define RST_INTER_CNT     16'h03E8
`define PCT_FULL          16'h03E8
`define JUMP_PCT_MAX      16'h01F4
`define PERIOD_MAX        16'h7530
`define PPM_MIN           16'h0001
`define CNT_MIN           16'h0001
`define LEN_SCALE         4'hA

// Terminal function codes
`define FN_CNT_IN         8'h19
`define FN_LEN_IN         8'h1B
`define FN_LEN_RST        8'h1C
`define FN_FINAL_HIT      8'h08
`define FN_INTER_HIT      8'h09
`define FN_LEN_HIT        8'h0A

// Timing: one swing tick is 0.1 ms; one period unit (0.1 s) holds 1000 ticks
`define CLK_PERIOD_NS     5
`define TICK_NS           100000
`define TICK_CYCLES       (`TICK_NS / `CLK_PERIOD_NS)

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### swing_pkg.sv
/*
  Types of the swing, length and count unit.
  Assumes nothing beyond a SystemVerilog elaborator.
*/
package swing_pkg;
  typedef enum logic [1:0] {
    DIV_IDLE  = 2'h0,
    DIV_SWING = 2'h1,
    DIV_LEN   = 2'h3
  } div_state_t;
endpackage
